// *** logic/dciq_top.sv ***
// Interrupt status/mask logic and panel data bus mapping of the display controller.
// Assumes event inputs and pixel stream are synchronous to CLK_SYS_I.
`timescale 1ns/10ps
`default_nettype none
module dciq_top #(
	parameter int BUF_DEPTH = dciq_pkg::BUF_DEPTH
) (
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	input wire logic DMA_BUS_ERR_I,
	input wire logic DMA_XFER_ACTIVE_I,
	input wire logic SER_READ_I,
	input wire logic FIFO_EMPTY_I,
	input wire logic DMA_FIFO_WRITE_I,
	input wire logic FIFO_FULL_I,
	input wire logic DMA_PTR_RELOAD_I,
	input wire logic LINE_BLANK_PERIOD_I,
	input wire logic LAST_LINE_I,
	input wire logic DMA_INACTIVE_I,
	input wire logic IRQ_ENABLE_WRITE_I,
	input wire logic IRQ_DISABLE_WRITE_I,
	input wire logic IRQ_CLEAR_WRITE_I,
	input wire logic [5:0] IRQ_WRITE_DATA_I,
	output logic [5:0] IRQ_MASK_VIEW_O,
	output logic [5:0] IRQ_PENDING_VIEW_O,
	output logic IRQ_O,
	input wire logic [2:0] MODE_I,
	input wire logic PIX_VALID_I,
	output logic PIX_READY_O,
	input wire logic [7:0] TFT_RED_BITS_I,
	input wire logic [7:0] TFT_GREEN_BITS_I,
	input wire logic [7:0] TFT_BLUE_BITS_I,
	input wire logic TFT_INTENSITY_I,
	input wire logic [7:0] UPPER_PANEL_BITS_I,
	input wire logic [7:0] LOWER_PANEL_BITS_I,
	output logic PANEL_VALID_O,
	input wire logic PANEL_READY_I,
	output logic [23:0] PANEL_DATA_BUS_O
);
	logic [5:0] mask_r, mask_nxt, pend_r, pend_nxt;
	logic [5:0] evt;
	logic blank_d_r, blank_d_nxt;
	logic [23:0] map_w;
	dciq_pkg::dciq_mode_e mode;
	dciq_stream_if #(.W(dciq_pkg::BUS_W)) s_in ();
	dciq_stream_if #(.W(dciq_pkg::BUS_W)) s_out ();
	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	always_comb begin
		blank_d_nxt = LINE_BLANK_PERIOD_I;
		evt = '0;
		evt[dciq_pkg::IRQ_MEM_ERR] = DMA_BUS_ERR_I && DMA_XFER_ACTIVE_I; // RULE3
		evt[dciq_pkg::IRQ_UNDERFLOW] = SER_READ_I && FIFO_EMPTY_I; // RULE4
		evt[dciq_pkg::IRQ_OVERWRITE] = DMA_FIFO_WRITE_I && FIFO_FULL_I; // RULE5
		evt[dciq_pkg::IRQ_END_FRAME] = DMA_PTR_RELOAD_I; // RULE6
		evt[dciq_pkg::IRQ_END_LINE] = LINE_BLANK_PERIOD_I && !blank_d_r
			&& DMA_INACTIVE_I; // RULE7
		evt[dciq_pkg::IRQ_END_LAST] = LINE_BLANK_PERIOD_I && !blank_d_r
			&& DMA_INACTIVE_I && LAST_LINE_I; // RULE8
	end
	// ----------------------------------------
	// Mask and status
	// ----------------------------------------
	always_comb begin
		mask_nxt = mask_r;
		if (IRQ_ENABLE_WRITE_I) begin
			mask_nxt = mask_nxt | IRQ_WRITE_DATA_I; // RULE9
		end
		if (IRQ_DISABLE_WRITE_I) begin
			mask_nxt = mask_nxt & ~IRQ_WRITE_DATA_I; // RULE9
		end
		pend_nxt = pend_r;
		if (IRQ_CLEAR_WRITE_I) begin
			pend_nxt = pend_nxt & ~IRQ_WRITE_DATA_I; // RULE9
		end
		pend_nxt = pend_nxt | evt; // RULE14
	end
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			mask_r <= dciq_pkg::MASK_RESET;
			pend_r <= dciq_pkg::PEND_RESET;
			blank_d_r <= 1'b0;
		end else begin
			mask_r <= mask_nxt;
			pend_r <= pend_nxt; // RULE2
			blank_d_r <= blank_d_nxt;
		end
	end
	assign IRQ_MASK_VIEW_O = mask_r; // RULE10
	assign IRQ_PENDING_VIEW_O = pend_r; // RULE10 RULE1
	assign IRQ_O = |(pend_r & mask_r); // RULE14
	// ----------------------------------------
	// Panel bit mapping
	// ----------------------------------------
	always_comb begin
		mode = dciq_pkg::dciq_mode_e'(MODE_I);
		map_w = dciq_pkg::BUS_RESET; // RULE15
		unique case (mode)
			dciq_pkg::DCIQ_STN4_SINGLE: begin
				map_w[3:0] = UPPER_PANEL_BITS_I[3:0]; // RULE13
			end
			dciq_pkg::DCIQ_STN8_SINGLE: begin
				map_w[7:0] = UPPER_PANEL_BITS_I; // RULE13
			end
			dciq_pkg::DCIQ_STN8_DUAL: begin
				map_w[3:0] = UPPER_PANEL_BITS_I[3:0]; // RULE13
				map_w[7:4] = LOWER_PANEL_BITS_I[3:0]; // RULE13
			end
			dciq_pkg::DCIQ_STN16_DUAL: begin
				map_w[7:0] = UPPER_PANEL_BITS_I; // RULE13
				map_w[15:8] = LOWER_PANEL_BITS_I; // RULE13
			end
			dciq_pkg::DCIQ_TFT24: begin
				map_w = {TFT_BLUE_BITS_I, TFT_GREEN_BITS_I, TFT_RED_BITS_I}; // RULE11
			end
			dciq_pkg::DCIQ_TFT16: begin
				map_w[23:18] = {TFT_BLUE_BITS_I[4:0], TFT_INTENSITY_I}; // RULE12
				map_w[15:10] = {TFT_GREEN_BITS_I[4:0], TFT_INTENSITY_I}; // RULE12
				map_w[7:2] = {TFT_RED_BITS_I[4:0], TFT_INTENSITY_I}; // RULE12
			end
			default: begin
				map_w = dciq_pkg::BUS_RESET; // RULE15
			end
		endcase
	end
	assign s_in.valid = PIX_VALID_I;
	assign s_in.data = map_w;
	assign PIX_READY_O = s_in.ready;
	dciq_buf #(
		.W(dciq_pkg::BUS_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RESET_N_I),
		.in_s(s_in),
		.out_s(s_out)
	);
	// ----------------------------------------
	// Output side, head of the buffer
	// ----------------------------------------
	assign s_out.ready = PANEL_READY_I;
	assign PANEL_VALID_O = s_out.valid;
	assign PANEL_DATA_BUS_O = s_out.data;
endmodule : dciq_top
`default_nettype wire

// *** logic/dciq_pkg.sv ***
// Constants, types and the operation list for the display irq and data mux block.
// Assumes a single core clock; users import nothing and write dciq_pkg::name.
//
// Operation
// RULE1: Six interrupt sources, one status bit each
// RULE2: All sources registered in the core clock
// RULE3: Bus error during DMA raises memory error
// RULE4: Serializer read on empty FIFO raises underflow
// RULE5: DMA write on full FIFO raises overwrite
// RULE6: Base pointer reload raises end of frame
// RULE7: Line blank start, DMA idle: end of line
// RULE8: Last line blank start, DMA idle: last line
// RULE9: Separate enable, disable, clear writes per source
// RULE10: Mask and pending status readable as ports
// RULE11: 24-bit TFT: blue high, green mid, red low
// RULE12: 16-bit TFT: five bits plus intensity per colour
// RULE13: STN single and dual scan bit ranges
// RULE14: Status sticky until cleared; masked OR interrupts
// RULE15: Unused panel bits driven low
package dciq_pkg;
	localparam int NUM_IRQ = 6;
	localparam int IRQ_MEM_ERR = 0;
	localparam int IRQ_UNDERFLOW = 1;
	localparam int IRQ_OVERWRITE = 2;
	localparam int IRQ_END_FRAME = 3;
	localparam int IRQ_END_LINE = 4;
	localparam int IRQ_END_LAST = 5;
	localparam logic [5:0] MASK_RESET = 6'h00;
	localparam logic [5:0] PEND_RESET = 6'h00;
	localparam int BUS_W = 24;
	localparam logic [23:0] BUS_RESET = 24'h000000;
	localparam int BUF_DEPTH = 2;
	typedef enum logic [2:0] {
		DCIQ_STN4_SINGLE,
		DCIQ_STN8_SINGLE,
		DCIQ_STN8_DUAL,
		DCIQ_STN16_DUAL,
		DCIQ_TFT24,
		DCIQ_TFT16
	} dciq_mode_e;
endpackage : dciq_pkg

// *** logic/dciq_stream_if.sv ***
// Valid/ready carrier of pixel words between the top and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface dciq_stream_if #(parameter int W = 24);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : dciq_stream_if
`default_nettype wire

// *** logic/dciq_buf.sv ***
// Two-entry skid buffer with valid and ready on both sides.
// Assumes synchronous inputs and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module dciq_buf #(
	parameter int W = 24,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	dciq_stream_if.snk in_s,
	dciq_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		push = in_s.valid && (cnt_r != (AW+1)'(DEPTH));
		pop = (cnt_r != '0) && out_s.ready;
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (push) begin
			mem_nxt[wp_r] = in_s.data;
			wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
		end
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_s.valid = (cnt_r != '0);
	assign out_s.data = mem_r[rp_r];
endmodule : dciq_buf
`default_nettype wire

// *** test/dciq_asserts.sv ***
// Concurrent checks on the ports of the display irq and data mux top.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module dciq_asserts (
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	input wire logic DMA_BUS_ERR_I,
	input wire logic DMA_XFER_ACTIVE_I,
	input wire logic SER_READ_I,
	input wire logic FIFO_EMPTY_I,
	input wire logic DMA_FIFO_WRITE_I,
	input wire logic FIFO_FULL_I,
	input wire logic DMA_PTR_RELOAD_I,
	input wire logic LINE_BLANK_PERIOD_I,
	input wire logic LAST_LINE_I,
	input wire logic DMA_INACTIVE_I,
	input wire logic IRQ_ENABLE_WRITE_I,
	input wire logic IRQ_DISABLE_WRITE_I,
	input wire logic IRQ_CLEAR_WRITE_I,
	input wire logic [5:0] IRQ_WRITE_DATA_I,
	input wire logic [5:0] IRQ_MASK_VIEW_O,
	input wire logic [5:0] IRQ_PENDING_VIEW_O,
	input wire logic IRQ_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESET_N_I);
	sequence s_blank_start;
		!LINE_BLANK_PERIOD_I ##1 LINE_BLANK_PERIOD_I && DMA_INACTIVE_I;
	endsequence
	a_irq_level: assert property (IRQ_O == |(IRQ_PENDING_VIEW_O & IRQ_MASK_VIEW_O))
		else $error("Combined irq level wrong");
	a_pend_sticky: assert property (!IRQ_CLEAR_WRITE_I |=>
		&(IRQ_PENDING_VIEW_O | ~$past(IRQ_PENDING_VIEW_O))) else $error("Pending bit lost");
	a_mem_err: assert property (DMA_BUS_ERR_I && DMA_XFER_ACTIVE_I |=> IRQ_PENDING_VIEW_O[0])
		else $error("Memory error not raised");
	a_fifo_under: assert property (SER_READ_I && FIFO_EMPTY_I |=> IRQ_PENDING_VIEW_O[1])
		else $error("Underflow not raised");
	a_fifo_over: assert property (DMA_FIFO_WRITE_I && FIFO_FULL_I |=> IRQ_PENDING_VIEW_O[2])
		else $error("Overwrite not raised");
	a_frame_end: assert property (DMA_PTR_RELOAD_I |=> IRQ_PENDING_VIEW_O[3])
		else $error("End of frame not raised");
	a_line_end: assert property (s_blank_start |=> IRQ_PENDING_VIEW_O[4])
		else $error("End of line not raised");
	a_last_line: assert property (s_blank_start ##0 LAST_LINE_I |=> IRQ_PENDING_VIEW_O[5])
		else $error("End of last line not raised");
	a_mask_set: assert property (IRQ_ENABLE_WRITE_I && !IRQ_DISABLE_WRITE_I |=>
		&(IRQ_MASK_VIEW_O | ~$past(IRQ_WRITE_DATA_I))) else $error("Enable not taken");
	a_mask_clear: assert property (IRQ_DISABLE_WRITE_I |=>
		!(|(IRQ_MASK_VIEW_O & $past(IRQ_WRITE_DATA_I)))) else $error("Disable not taken");
endmodule : dciq_asserts
bind dciq_top dciq_asserts i_dciq_asserts (.*);
`default_nettype wire

// *** test/dciq_panel_model.sv ***
// Panel receiver on the pixel data bus, able to stall.
// Assumes the core clock and the bench's reset.
`timescale 1ns/10ps
`default_nettype none
module dciq_panel_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic valid_i,
	input wire logic [23:0] data_i,
	input wire logic stall_i,
	output logic ready_o,
	output logic got_o,
	output logic [23:0] word_o
);
	assign ready_o = !stall_i;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			got_o <= 1'b0;
			word_o <= 24'h000000;
		end else begin
			got_o <= valid_i && ready_o;
			word_o <= data_i;
		end
	end
endmodule : dciq_panel_model
`default_nettype wire

// *** test/display_ctrl_irq_and_data_mux_test.sv ***
// Self-checking bench: irq enable, clear and status, then panel bus mapping.
// Assumes the design files and the panel model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module display_ctrl_irq_and_data_mux_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] ev = 10'h000;
	logic [2:0] ws = 3'h0;
	logic [5:0] wd = 6'h00;
	logic [2:0] mode = 3'h0;
	logic pv = 1'b0;
	logic stall = 1'b1;
	logic ti = 1'b1;
	logic [7:0] r = 8'h6b, g = 8'hd4, b = 8'h39, up = 8'ha6, lo = 8'h5e;
	logic [5:0] mask, pend;
	logic irq, pr, vld, prdy, got;
	logic [23:0] bus, word;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [9:0] pat [8] = '{10'h003, 10'h00c, 10'h030, 10'h040, 10'h280, 10'h380, 10'h001, 10'h080};
	logic [5:0] ep [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h30, 6'h00, 6'h00};
	always #10 clk = ~clk;
	dciq_top i_dciq_top (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .DMA_BUS_ERR_I(ev[0]),
		.DMA_XFER_ACTIVE_I(ev[1]), .SER_READ_I(ev[2]), .FIFO_EMPTY_I(ev[3]),
		.DMA_FIFO_WRITE_I(ev[4]), .FIFO_FULL_I(ev[5]), .DMA_PTR_RELOAD_I(ev[6]),
		.LINE_BLANK_PERIOD_I(ev[7]), .LAST_LINE_I(ev[8]), .DMA_INACTIVE_I(ev[9]),
		.IRQ_ENABLE_WRITE_I(ws[0]), .IRQ_DISABLE_WRITE_I(ws[1]), .IRQ_CLEAR_WRITE_I(ws[2]),
		.IRQ_WRITE_DATA_I(wd), .IRQ_MASK_VIEW_O(mask), .IRQ_PENDING_VIEW_O(pend), .IRQ_O(irq),
		.MODE_I(mode), .PIX_VALID_I(pv), .PIX_READY_O(pr), .TFT_RED_BITS_I(r),
		.TFT_GREEN_BITS_I(g), .TFT_BLUE_BITS_I(b), .TFT_INTENSITY_I(ti),
		.UPPER_PANEL_BITS_I(up), .LOWER_PANEL_BITS_I(lo), .PANEL_VALID_O(vld),
		.PANEL_READY_I(prdy), .PANEL_DATA_BUS_O(bus));
	dciq_panel_model i_dciq_panel_model (.clk_i(clk), .rst_n_i(rst_n), .valid_i(vld),
		.data_i(bus), .stall_i(stall), .ready_o(prdy), .got_o(got), .word_o(word));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task close_out;
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [2:0] s, input logic [5:0] d);
		@(posedge clk);
		ws <= s;
		wd <= d;
		@(posedge clk);
		ws <= 3'h0;
		#1;
	endtask : wr
	task tx(input logic [2:0] m);
		@(posedge clk);
		pv <= 1'b1;
		mode <= m;
		#1;
		while (pr !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		pv <= 1'b0;
	endtask : tx
	task rx(input logic [23:0] e);
		@(posedge clk);
		#1;
		while (got !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		chk(word, e);
	endtask : rx
	function automatic logic [23:0] ex(input logic [2:0] m);
		case (m)
			3'h0: return {20'h00000, up[3:0]};
			3'h1: return {16'h0000, up};
			3'h2: return {16'h0000, lo[3:0], up[3:0]};
			3'h3: return {8'h00, lo, up};
			3'h4: return {b, g, r};
			3'h5: return {b[4:0], ti, 2'h0, g[4:0], ti, 2'h0, r[4:0], ti, 2'h0};
			default: return 24'h000000;
		endcase
	endfunction : ex
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			close_out;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({mask, pend, irq, vld, pr}, {6'h00, 6'h00, 3'h1});
		chk(bus, 24'h000000);
		wr(3'h1, 6'h3f);
		chk(mask, 6'h3f);
		wr(3'h2, 6'h05);
		chk(mask, 6'h3a);
		wr(3'h3, 6'h01);
		chk(mask, 6'h3a);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			ev <= pat[k];
			@(posedge clk);
			ev <= 10'h000;
			repeat (3) @(posedge clk);
			#1;
			chk({irq, pend}, {|(ep[k] & 6'h3a), ep[k]});
			wr(3'h4, ep[k]);
			chk(pend, 6'h00);
		end
		@(posedge clk);
		ev <= pat[3];
		ws <= 3'h4;
		wd <= 6'h08;
		@(posedge clk);
		ev <= 10'h000;
		ws <= 3'h0;
		#1;
		chk(pend, 6'h08);
		wr(3'h4, 6'h08);
		chk(pend, 6'h00);
		tx(3'h0);
		tx(3'h1);
		#1;
		chk({pr, vld}, 2'h1);
		@(posedge clk);
		stall <= 1'b0;
		rx(ex(3'h0));
		rx(ex(3'h1));
		for (int m = 0; m < 8; m++) begin
			tx(m[2:0]);
			rx(ex(m[2:0]));
		end
		close_out;
	end
endmodule : display_ctrl_irq_and_data_mux_test
`default_nettype wire
